// [shared/fault_flags_pkg.sv]
// Purpose: Constants and carrier types for the limit fault status flag bank
// Assumes: Wishbone classic slave, 32-bit data, byte addresses = index * 4
// Notes:   Register offsets are word indices; byte address is four times each
package fault_flags_pkg;

    // =====================================================================
    // Register map (word indices, byte address = index * 4)
    // =====================================================================
    localparam logic [7:0] IDX_STATUS_PRI   = 8'h41;
    localparam logic [7:0] IDX_STATUS_SEC   = 8'h42;
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h60;
    localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h61;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h62;
    localparam int         ADDR_W           = 10;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [1:0] IRQ_EN_RESET     = 2'h0;

    // =====================================================================
    // Field positions, primary register
    // =====================================================================
    localparam int PRI_V25_BIT   = 0;
    localparam int PRI_CORE_BIT  = 1;
    localparam int PRI_V33_BIT   = 2;
    localparam int PRI_V5_BIT    = 3;
    localparam int PRI_ZONE1_BIT = 4;
    localparam int PRI_ZONE2_BIT = 5;
    localparam int PRI_ZONE3_BIT = 6;
    localparam int PRI_SUM_BIT   = 7;

    // Field positions, secondary register
    localparam int SEC_V12_BIT   = 0;
    localparam int SEC_RSVD_BIT  = 1;
    localparam int SEC_FAN0_BIT  = 2;
    localparam int SEC_D1_BIT    = 6;
    localparam int SEC_D2_BIT    = 7;

    // Interrupt status layout: one bit per new-fault event of each register
    localparam int IRQ_PRI_BIT   = 0;
    localparam int IRQ_SEC_BIT   = 1;

    localparam int NUM_FANS      = 4;
    localparam int NUM_VOLTS     = 5;

    // =====================================================================
    // Carrier types
    // =====================================================================
    typedef struct packed {
        logic [7:0] reading;
        logic [7:0] low;
        logic [7:0] high;
    } window_8_t;

    typedef struct packed {
        logic [15:0] reading;
        logic [15:0] minimum;
    } tach_check_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADDR_W-1:0] adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// [hdl/window_compare.sv]
// Purpose: Out-of-window test on one 8-bit reading against low/high limits
// Assumes: Limits and reading share one encoding, chosen by is_signed
// Notes:   incl_low picks "at or below" versus "strictly below" for the low edge
module window_compare #(
    parameter bit IS_SIGNED = 1'b0,
    parameter bit INCL_LOW  = 1'b1
) (
    input  fault_flags_pkg::window_8_t win,
    output logic                       outside
);
    logic below;
    logic above;

    // Signed compare used for temperatures in two's complement degrees
    always_comb begin
        if (IS_SIGNED) begin
            below = INCL_LOW ? ($signed(win.reading) <= $signed(win.low))
                             : ($signed(win.reading) <  $signed(win.low));
            above = $signed(win.reading) > $signed(win.high);
        end else begin
            below = INCL_LOW ? (win.reading <= win.low) : (win.reading < win.low);
            above = win.reading > win.high;
        end
        outside = below | above;
    end
endmodule

// [hdl/tach_compare.sv]
// Purpose: Stall test of one tachometer count against its 16-bit minimum
// Assumes: A larger count means a slower fan
// Notes:   Purely combinational; the flag bank latches the result
module tach_compare (
    input  fault_flags_pkg::tach_check_t chk,
    output logic                         stalled
);
    // Count above the threshold means the fan turns too slowly
    assign stalled = chk.reading > chk.minimum;
endmodule

// [hdl/limit_fault_status_flags.sv]
// Purpose: Two sticky clear-on-read fault status registers behind Wishbone
// Assumes: Readings and limits arrive synchronous to clk from outside engines
// Notes:   Read data is registered; clear-on-read acts at the ack edge
//
// Chosen here: the Wishbone interface to the registers.
module limit_fault_status_flags #(
    parameter int NUM_FANS = fault_flags_pkg::NUM_FANS
) (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [3:0]                           wb_sel_i,
    input  wire logic [fault_flags_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [31:0]                          wb_dat_i,
    output logic [31:0]                               wb_dat_o,
    output logic                                      wb_ack_o,
    input  fault_flags_pkg::window_8_t                volt_v25,
    input  fault_flags_pkg::window_8_t                volt_core_supply,
    input  fault_flags_pkg::window_8_t                volt_v33,
    input  fault_flags_pkg::window_8_t                volt_v5,
    input  fault_flags_pkg::window_8_t                volt_v12,
    input  fault_flags_pkg::window_8_t                temp_zone1,
    input  fault_flags_pkg::window_8_t                temp_zone2,
    input  fault_flags_pkg::window_8_t                temp_zone3,
    input  fault_flags_pkg::tach_check_t [NUM_FANS-1:0] tach_in,
    input  wire logic                                 diode1_fault,
    input  wire logic                                 diode2_fault,
    output logic                                      irq
);

    // =====================================================================
    // Live fault conditions
    // =====================================================================
    logic v25_out;
    logic core_out;
    logic v33_out;
    logic v5_out;
    logic v12_out;
    logic z1_out;
    logic z2_out;
    logic z3_out;
    logic [NUM_FANS-1:0] fan_stall;
    logic [7:0] pri_live;
    logic [7:0] sec_live;

    // Supplies: at-or-below low counts as a fault
    window_compare #(.IS_SIGNED(1'b0), .INCL_LOW(1'b1)) u_v25 (.win(volt_v25), .outside(v25_out));
    window_compare #(.IS_SIGNED(1'b0), .INCL_LOW(1'b1)) u_core (.win(volt_core_supply),
                                                                .outside(core_out));
    window_compare #(.IS_SIGNED(1'b0), .INCL_LOW(1'b1)) u_v33 (.win(volt_v33), .outside(v33_out));
    window_compare #(.IS_SIGNED(1'b0), .INCL_LOW(1'b1)) u_v5 (.win(volt_v5), .outside(v5_out));
    // The 12V input uses strict bounds on both edges
    window_compare #(.IS_SIGNED(1'b0), .INCL_LOW(1'b0)) u_v12 (.win(volt_v12),
                                                               .outside(v12_out));
    // Zone 3 low limit is fed from outside; integration ties it to zone 2 low
    window_compare #(.IS_SIGNED(1'b1), .INCL_LOW(1'b1)) u_z1 (.win(temp_zone1),
                                                              .outside(z1_out));
    window_compare #(.IS_SIGNED(1'b1), .INCL_LOW(1'b1)) u_z2 (.win(temp_zone2), .outside(z2_out));
    window_compare #(.IS_SIGNED(1'b1), .INCL_LOW(1'b1)) u_z3 (.win(temp_zone3), .outside(z3_out));

    // One stall comparator per tachometer input
    generate
        for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
            tach_compare u_tach (.chk(tach_in[f]), .stalled(fan_stall[f]));
        end
    endgenerate

    // Assemble live condition vectors in register layout
    always_comb begin
        sec_live = 8'h00;
        sec_live[fault_flags_pkg::SEC_V12_BIT] = v12_out;
        sec_live[fault_flags_pkg::SEC_FAN0_BIT +: NUM_FANS] = fan_stall;
        sec_live[fault_flags_pkg::SEC_D1_BIT] = diode1_fault;
        sec_live[fault_flags_pkg::SEC_D2_BIT] = diode2_fault;
        pri_live = 8'h00;
        pri_live[fault_flags_pkg::PRI_V25_BIT]   = v25_out;
        pri_live[fault_flags_pkg::PRI_CORE_BIT]  = core_out;
        pri_live[fault_flags_pkg::PRI_V33_BIT]   = v33_out;
        pri_live[fault_flags_pkg::PRI_V5_BIT]    = v5_out;
        pri_live[fault_flags_pkg::PRI_ZONE1_BIT] = z1_out | diode1_fault;
        pri_live[fault_flags_pkg::PRI_ZONE2_BIT] = z2_out;
        pri_live[fault_flags_pkg::PRI_ZONE3_BIT] = z3_out | diode2_fault;
        pri_live[fault_flags_pkg::PRI_SUM_BIT]   = 1'b0;
    end

    // =====================================================================
    // Wishbone slave
    // =====================================================================
    logic [7:0] fault_status_primary_reg;
    logic [7:0] fault_status_secondary_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_enable_reg;
    logic       req;
    logic       rd_pri;
    logic       rd_sec;
    logic       wr_clr;
    logic [7:0] idx;

    // One-cycle ack; req drops for the cycle after ack so each access acts once
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx    = wb_adr_i[fault_flags_pkg::ADDR_W-1:2];
    assign rd_pri = req & ~wb_we_i & (idx == fault_flags_pkg::IDX_STATUS_PRI);
    assign rd_sec = req & ~wb_we_i & (idx == fault_flags_pkg::IDX_STATUS_SEC);
    assign wr_clr = req & wb_we_i & wb_sel_i[0] & (idx == fault_flags_pkg::IDX_IRQ_CLEAR);

    // Ack every access, mapped or not, so the master never hangs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read mux captures the sticky contents before the clear lands
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            case (idx)
                fault_flags_pkg::IDX_STATUS_PRI: wb_dat_o <= {24'h000000,
                                                 fault_status_primary_reg};
                fault_flags_pkg::IDX_STATUS_SEC: wb_dat_o <= {24'h000000,
                                                 fault_status_secondary_reg};
                fault_flags_pkg::IDX_IRQ_ENABLE: wb_dat_o <= {30'h00000000, irq_enable_reg};
                fault_flags_pkg::IDX_IRQ_STATUS: wb_dat_o <= {30'h00000000, irq_status_reg};
                default:                         wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // =====================================================================
    // Sticky flags
    // =====================================================================
    logic [7:0] sec_next;
    logic [7:0] pri_next;

    // Writes never reach these registers; only live faults and reads act
    always_comb begin
        sec_next = fault_status_secondary_reg;
        if (rd_sec) begin
            sec_next = sec_live;
        end
        sec_next = sec_next | sec_live;
        sec_next[fault_flags_pkg::SEC_RSVD_BIT] = 1'b0;
        pri_next = fault_status_primary_reg;
        if (rd_pri) begin
            pri_next = pri_live;
        end
        pri_next = pri_next | pri_live;
        // Summary follows the secondary contents so it cannot drift out of step
        pri_next[fault_flags_pkg::PRI_SUM_BIT] = |sec_next;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_status_primary_reg   <= fault_flags_pkg::STATUS_RESET;
            fault_status_secondary_reg <= fault_flags_pkg::STATUS_RESET;
        end else begin
            fault_status_primary_reg   <= pri_next;
            fault_status_secondary_reg <= sec_next;
        end
    end

    // =====================================================================
    // Interrupt: new-flag events, enable, write-one-to-clear
    // =====================================================================
    logic [1:0] irq_set;
    assign irq_set[fault_flags_pkg::IRQ_PRI_BIT] = |(pri_next & ~fault_status_primary_reg);
    assign irq_set[fault_flags_pkg::IRQ_SEC_BIT] = |(sec_next & ~fault_status_secondary_reg);

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_clr ? wb_dat_i[1:0] : 2'h0)) | irq_set;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_enable_reg <= fault_flags_pkg::IRQ_EN_RESET;
        end else if (req && wb_we_i && wb_sel_i[0] && idx == fault_flags_pkg::IDX_IRQ_ENABLE) begin
            irq_enable_reg <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_status_reg & ~(wr_clr ? wb_dat_i[1:0] : 2'h0)) | irq_set)
                     & irq_enable_reg);
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    chk_live_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (pri_live != 8'h00) |=> ((fault_status_primary_reg & $past(pri_live)) == $past(pri_live)))
        else $error("live primary fault not latched");
    chk_flag_holds: assert property (@(posedge clk) disable iff (!reset_n)
        (fault_status_secondary_reg[0] && !rd_sec) |=> fault_status_secondary_reg[0])
        else $error("secondary flag dropped without a read");
    chk_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_pri && pri_live[6:0] == 7'h00 && sec_live == 8'h00) |=>
            fault_status_primary_reg[6:0] == 7'h00)
        else $error("primary not cleared after read");
    chk_write_ignored: assert property (@(posedge clk) disable iff (!reset_n)
        (req && wb_we_i && pri_live == 8'h00 && sec_live == 8'h00) |=>
            (fault_status_secondary_reg == $past(fault_status_secondary_reg)) &&
            (fault_status_primary_reg == $past(fault_status_primary_reg)))
        else $error("write changed status");
    chk_read_data: assert property (@(posedge clk) disable iff (!reset_n)
        rd_sec |=> wb_dat_o[7:0] == $past(fault_status_secondary_reg))
        else $error("read data mismatch");
    chk_summary_bit: assert property (@(posedge clk) disable iff (!reset_n)
        fault_status_primary_reg[7] == (fault_status_secondary_reg != 8'h00))
        else $error("summary bit wrong");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        !fault_status_secondary_reg[1])
        else $error("reserved bit set");
    chk_diode_zone: assert property (@(posedge clk) disable iff (!reset_n)
        diode2_fault |=> fault_status_primary_reg[6] && fault_status_secondary_reg[7])
        else $error("diode fault not reflected");
    chk_ack_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    cov_primary_read: cover property (@(posedge clk) disable iff (!reset_n)
        rd_pri && fault_status_primary_reg != 8'h00);
    cov_clear_blocked: cover property (@(posedge clk) disable iff (!reset_n)
        rd_sec && sec_live != 8'h00);
    cov_irq_raised: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
endmodule

// [testbench/wb_host_model.sv]
// Purpose: Host software model issuing classic Wishbone single cycles
// Assumes: One access at a time, started right after a rising clock edge
// Notes:   Address and data are inverted on release so stale values never look valid
module wb_host_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [3:0]       sel,
    output logic [9:0]       adr,
    output logic [31:0]      wdat
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Idle bus at time zero
    // =====================================================================
    initial begin
        cyc  = 1'b0;
        stb  = 1'b0;
        we   = 1'b0;
        sel  = 4'h0;
        adr  = 10'h000;
        wdat = 32'h00000000;
    end

    // Request held unchanged until ack is sampled high; bounded wait
    task automatic access(input logic w, input logic [9:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'hF;
        adr  <= a;
        wdat <= d;
        ok = 1'b0;
        q = 32'h00000000;
        for (n = 0; n < 64 && ok !== 1'b1; n++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                ok = 1'b1;
                q = rdat;
            end
        end
        cyc  <= 1'b0;
        stb  <= 1'b0;
        adr  <= ~a;
        wdat <= ~d;
    endtask
endmodule

// [testbench/tb_limit_fault_status_flags.sv]
// Purpose: Self-checking bench for the sticky fault status flag bank
// Assumes: Flags land one edge after a live fault; three edges are allowed
// Notes:   Expected values follow the window edges and bit layout of each flag
module tb_limit_fault_status_flags;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Addresses and signals
    // =====================================================================
    localparam logic [9:0] A_PRI = {fault_flags_pkg::IDX_STATUS_PRI, 2'h0};
    localparam logic [9:0] A_SEC = {fault_flags_pkg::IDX_STATUS_SEC, 2'h0};
    localparam logic [9:0] A_EN  = {fault_flags_pkg::IDX_IRQ_ENABLE, 2'h0};
    localparam logic [9:0] A_CLR = {fault_flags_pkg::IDX_IRQ_CLEAR, 2'h0};
    localparam logic [9:0] A_IST = {fault_flags_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [9:0] A_BAD = 10'h3FC;
    logic                              clk;
    logic                              reset_n;
    logic                              wb_cyc;
    logic                              wb_stb;
    logic                              wb_we;
    logic                              wb_ack;
    logic                              irq;
    logic                              d1;
    logic                              d2;
    logic [3:0]                        wb_sel;
    logic [9:0]                        wb_adr;
    logic [31:0]                       wb_wdat;
    logic [31:0]                       wb_rdat;
    fault_flags_pkg::window_8_t        volt [5];
    fault_flags_pkg::window_8_t        z1;
    fault_flags_pkg::window_8_t        z2;
    fault_flags_pkg::window_8_t        z3;
    fault_flags_pkg::tach_check_t [3:0] tach;
    int                                fails;
    int                                cmp_count;
    int                                cyc_cnt;

    limit_fault_status_flags i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .volt_v25(volt[0]),
        .volt_core_supply(volt[1]), .volt_v33(volt[2]), .volt_v5(volt[3]),
        .volt_v12(volt[4]), .temp_zone1(z1), .temp_zone2(z2), .temp_zone3(z3),
        .tach_in(tach), .diode1_fault(d1), .diode2_fault(d2), .irq(irq));

    wb_host_model i_host (.clk(clk), .ack(wb_ack), .rdat(wb_rdat), .cyc(wb_cyc),
        .stb(wb_stb), .we(wb_we), .sel(wb_sel), .adr(wb_adr), .wdat(wb_wdat));

    // =====================================================================
    // Clock and hang guard; a hang ends the run as a mismatch
    // =====================================================================
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 6000) begin
            fails++;
            report_and_stop();
        end
    end

    // =====================================================================
    // Compare, access and closing tasks
    // =====================================================================
    task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic        ok;
        i_host.access(1'b0, a, 32'h00000000, q, ok);
        cmp1("ack", 1'b1, ok);
        cmp32($sformatf("reg %h", a), e, q);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        ok;
        i_host.access(1'b1, a, d, q, ok);
        cmp1("ack", 1'b1, ok);
    endtask

    // Three edges are ample; flag latch, event bit and registered irq all land on the first
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        fails = 0;
        cmp_count = 0;
        cyc_cnt = 0;
        reset_n = 1'b0;
        d1 = 1'b0;
        d2 = 1'b0;
        for (int i = 0; i < 5; i++) volt[i] = '{8'h80, 8'h10, 8'hF0};
        z1 = '{8'h19, 8'hCE, 8'h50};
        z2 = '{8'h19, 8'hCE, 8'h50};
        z3 = '{8'h19, 8'hCE, 8'h50};
        for (int i = 0; i < 4; i++) tach[i] = '{16'h1000, 16'h2000};
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(A_PRI, 32'h00000000);
        rd(A_SEC, 32'h00000000);
        rd(A_EN, 32'h00000000);
        $display("test reset finished");
        // Low edge is inclusive; a flag outlives its fault until read
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            volt[i].reading <= 8'h10;
            settle();
            volt[i].reading <= 8'h80;
            settle();
            rd(A_PRI, 32'h1 << i);
            rd(A_PRI, 32'h00000000);
        end
        // High edge is strict; a persisting fault survives its read
        volt[0].reading <= 8'hF0;
        settle();
        rd(A_PRI, 32'h00000000);
        volt[0].reading <= 8'hF1;
        settle();
        rd(A_PRI, 32'h00000001);
        volt[0].reading <= 8'h80;
        settle();
        rd(A_PRI, 32'h00000001);
        rd(A_PRI, 32'h00000000);
        // Twelve volt window is strict at the low edge; summary bit follows
        volt[4].reading <= 8'h10;
        settle();
        rd(A_SEC, 32'h00000000);
        volt[4].reading <= 8'h0F;
        settle();
        volt[4].reading <= 8'h80;
        settle();
        rd(A_PRI, 32'h00000080);
        rd(A_SEC, 32'h00000001);
        rd(A_PRI, 32'h00000000);
        $display("test supply windows finished");
        // Signed compare: F0 is -16, inside a -50..80 window
        z1.reading <= 8'hCE;
        z2.reading <= 8'hF0;
        z3.reading <= 8'h51;
        settle();
        z1.reading <= 8'h19;
        z2.reading <= 8'hCE;
        z3.reading <= 8'h19;
        settle();
        z2.reading <= 8'h19;
        settle();
        rd(A_PRI, 32'h00000070);
        rd(A_PRI, 32'h00000000);
        // Stall needs a count strictly above the minimum
        for (int i = 0; i < 4; i++) tach[i].reading <= 16'h2000;
        settle();
        rd(A_SEC, 32'h00000000);
        for (int i = 0; i < 4; i++) tach[i].reading <= 16'h2001;
        settle();
        for (int i = 0; i < 4; i++) tach[i].reading <= 16'h1000;
        settle();
        rd(A_PRI, 32'h00000080);
        rd(A_SEC, 32'h0000003C);
        $display("test temperatures and fans finished");
        // Diode faults set both registers; bit 7 tracks the secondary
        d1 <= 1'b1;
        d2 <= 1'b1;
        settle();
        rd(A_PRI, 32'h000000D0);
        rd(A_SEC, 32'h000000C0);
        d1 <= 1'b0;
        d2 <= 1'b0;
        settle();
        rd(A_PRI, 32'h000000D0);
        rd(A_PRI, 32'h00000080);
        rd(A_SEC, 32'h000000C0);
        rd(A_PRI, 32'h00000000);
        $display("test diode faults finished");
        // Writes leave both status registers as they were
        volt[0].reading <= 8'h00;
        settle();
        volt[0].reading <= 8'h80;
        wr(A_PRI, 32'h00000000);
        wr(A_SEC, 32'h000000FF);
        rd(A_PRI, 32'h00000001);
        rd(A_SEC, 32'h00000000);
        rd(A_BAD, 32'h00000000);
        $display("test read only finished");
        // Interrupt: both event bits pending, clear, raise while masked, enable, clear
        rd(A_IST, 32'h00000003);
        wr(A_CLR, 32'h00000003);
        rd(A_IST, 32'h00000000);
        cmp1("irq", 1'b0, irq);
        volt[3].reading <= 8'hF5;
        settle();
        volt[3].reading <= 8'h80;
        rd(A_IST, 32'h00000001);
        cmp1("irq", 1'b0, irq);
        wr(A_EN, 32'h00000001);
        settle();
        rd(A_EN, 32'h00000001);
        cmp1("irq", 1'b1, irq);
        wr(A_CLR, 32'h00000001);
        settle();
        cmp1("irq", 1'b0, irq);
        rd(A_IST, 32'h00000000);
        rd(A_PRI, 32'h00000008);
        $display("test interrupt finished");
        // Mid-run reset drops latched flags, enables and the registered outputs
        volt[1].reading <= 8'h00;
        settle();
        volt[1].reading <= 8'h80;
        cmp1("irq", 1'b1, irq);
        reset_n <= 1'b0;
        settle();
        cmp1("irq", 1'b0, irq);
        cmp32("rdat", 32'h00000000, wb_rdat);
        reset_n <= 1'b1;
        rd(A_PRI, 32'h00000000);
        rd(A_IST, 32'h00000000);
        rd(A_EN, 32'h00000000);
        $display("test reset again finished");
        report_and_stop();
    end
endmodule
